// ==== rtl/scc_pkg.sv ====
package scc_pkg;
  // Byte role and command codes.
  localparam int  ROLE_BIT          = 7;
  localparam logic [3:0] ID_PREFIX  = 4'hf;
  localparam logic [3:0] CMD_CLOCK  = 4'h0;
  localparam logic [3:0] CMD_ACQ    = 4'h1;
  localparam logic [3:0] CMD_CHECK  = 4'h2;
  localparam logic [3:0] CMD_SYNC1  = 4'h3;
  localparam logic [3:0] CMD_SYNC2  = 4'h4;
  localparam int  NUM_REGS          = 5;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // Field positions in the data byte of the clock command.
  localparam int  FREQ_A_POS        = 6;
  localparam int  FREQ_B_POS        = 5;
  localparam int  FREQ_C_POS        = 4;
  localparam int  TEST_POS          = 2;
  localparam int  SOFT_RST_POS      = 0;
  // Other field positions.
  localparam int  PHASE_LSB         = 4;
  localparam int  MODE_LSB          = 0;
  localparam int  MASK_EARLY_POS    = 6;
  localparam int  MASK_LEN_POS      = 5;
  localparam int  RUN_IN_POS        = 4;
  localparam int  FRAMING_POS       = 3;
  localparam int  BYPASS_POS        = 2;
  localparam int  POLICY_POS        = 1;
  localparam int  UNUSED_OFF_POS    = 0;
  localparam int  ACQ_CNT_LSB       = 4;
  localparam int  LOSS_CNT_LSB      = 0;
  localparam int  RANGE_EXT_POS     = 5;

  // Reference clock selections.
  typedef enum logic [2:0] {
    SCC_REF_2FSC    = 3'b000,
    SCC_REF_4FSC    = 3'b100,
    SCC_REF_FSC     = 3'b011,
    SCC_REF_2FSC_NR = 3'b001
  } scc_ref_e;

  // Acquisition modes.
  localparam logic [3:0] MODE_VPS     = 4'h0;
  localparam logic [3:0] MODE_PDC     = 4'h1;
  localparam logic [3:0] MODE_AUTO1   = 4'h2;
  localparam logic [3:0] MODE_UDT     = 4'h3;
  localparam logic [3:0] MODE_HDR1    = 4'h4;
  localparam logic [3:0] MODE_STAT1   = 4'h8;
  localparam logic [3:0] MODE_PALPULS = 4'hc;
  localparam logic [3:0] MODE_AUTO2   = 4'hd;

  // Line counts for sync detection.
  localparam logic [8:0] CNT_4   = 9'h004;
  localparam logic [8:0] CNT_8   = 9'h008;
  localparam logic [8:0] CNT_16  = 9'h010;
  localparam logic [8:0] CNT_32  = 9'h020;
  localparam logic [8:0] CNT_64  = 9'h040;
  localparam logic [8:0] CNT_128 = 9'h080;
  localparam logic [8:0] CNT_256 = 9'h100;
  localparam logic [8:0] CNT_0   = 9'h000;
  localparam int PHASE_STEP_CYCLES = 8;
endpackage

// ==== rtl/scc_byte_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser; the command block uses it to retime the release of reset.
module scc_byte_sync
  import scc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;
  logic next_stage1;
  logic next_sync;

  // Next values hold while the clock enable is low.
  always_comb begin
    next_stage1 = ce ? async_in : stage1;
    next_sync   = ce ? stage1 : sync_out;
  end

  // Register both stages.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/scc_count_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
// Decodes the presence and absence count fields into line counts.
module scc_count_decode
  import scc_pkg::*;
(
  input  wire logic [2:0] acq_code,
  input  wire logic [3:0] loss_code,
  input  wire logic       range_ext,
  output logic [8:0]      acq_lines,
  output logic            acq_valid,
  output logic [8:0]      loss_lines,
  output logic            loss_enable,
  output logic            loss_valid
);
  // Presence count, normal or extended table; unlisted codes flag invalid.
  always_comb begin
    acq_valid = 1'b1;
    unique case (acq_code)
      3'b000:  acq_lines = range_ext ? CNT_32  : CNT_0;
      3'b001:  acq_lines = range_ext ? CNT_64  : CNT_4;
      3'b010:  acq_lines = range_ext ? CNT_128 : CNT_8;
      3'b100:  acq_lines = range_ext ? CNT_256 : CNT_16;
      default: begin
        acq_lines = CNT_0;
        acq_valid = 1'b0;
      end
    endcase
  end

  // Absence count; zero disables detection, only one-hot codes are defined.
  always_comb begin
    loss_valid  = 1'b1;
    loss_enable = 1'b1;
    unique case (loss_code)
      4'b0000: begin
        loss_lines  = CNT_0;
        loss_enable = 1'b0;
      end
      4'b0001: loss_lines = CNT_32;
      4'b0010: loss_lines = CNT_64;
      4'b0100: loss_lines = CNT_128;
      4'b1000: loss_lines = CNT_256;
      default: begin
        loss_lines  = CNT_0;
        loss_enable = 1'b0;
        loss_valid  = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== rtl/scc_command_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
module scc_command_regs
  import scc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  output logic [2:0]      ref_select,
  output logic            ref_select_known,
  output logic            phase_resistor_used,
  output logic            test_mode_bit,
  output logic [2:0]      acq_phase,
  output logic [5:0]      acq_phase_offset,
  output logic [3:0]      slicer_mode,
  output logic            mode_auto,
  output logic            mode_header,
  output logic            mode_status,
  output logic [1:0]      check_kind,
  output logic            mask_early_start,
  output logic            mask_length_sel,
  output logic            run_in_count_sel,
  output logic            framing_tolerance_sel,
  output logic            check_bypass,
  output logic            errored_byte_policy,
  output logic            unused_byte_check_off,
  output logic [8:0]      acq_lines,
  output logic            acq_code_valid,
  output logic [8:0]      loss_lines,
  output logic            loss_detect_enable,
  output logic            loss_code_valid,
  output logic            acquire_range_ext
);
  logic [7:0] regs [NUM_REGS];
  logic [7:0] next_regs [NUM_REGS];
  logic [3:0] cmd_sel;
  logic [3:0] next_cmd_sel;
  logic       cmd_valid;
  logic       next_cmd_valid;
  logic       is_id_byte;
  logic       soft_reset;
  logic       byte_take;
  logic       rst_released;
  logic [2:0] next_ref_code;
  logic       next_ref_known;
  logic       next_resistor_used;
  logic [2:0] next_phase_pos;
  logic [5:0] next_phase_offset;
  logic [3:0] next_mode;
  logic       next_mode_auto;
  logic       next_mode_header;
  logic       next_mode_status;
  logic [1:0] next_check_kind;
  logic [8:0] next_acq_lines;
  logic       next_acq_valid;
  logic [8:0] next_loss_lines;
  logic       next_loss_enable;
  logic       next_loss_valid;

  // Reset release is retimed through two flops, so a byte that arrives just as the pin
  // lets go cannot be taken by some flops and missed by others. Bytes in the first two
  // enabled cycles after release are ignored.
  scc_byte_sync u_rst_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .async_in (1'b1),
    .sync_out (rst_released)
  );

  // A byte is taken only with the clock enabled and reset fully released.
  assign byte_take = ce && byte_valid && rst_released;

  // A command byte has bit 7 set; the upper nibble must be all ones.
  // byte role decode
  assign is_id_byte = byte_data[ROLE_BIT] && (byte_data[7:4] == ID_PREFIX);

  assign soft_reset = byte_valid && cmd_valid && !byte_data[ROLE_BIT] &&
                      (cmd_sel == CMD_CLOCK) && byte_data[SOFT_RST_POS];

  // Command pointer: set by a command byte, stepped by each data byte while the command is valid.
  // pointer hold and increment
  always_comb begin
    next_cmd_sel   = cmd_sel;
    next_cmd_valid = cmd_valid;
    if (byte_take) begin
      if (byte_data[ROLE_BIT]) begin
        next_cmd_sel   = byte_data[3:0];
        next_cmd_valid = is_id_byte;
      end else if (cmd_valid && (cmd_sel < 4'(NUM_REGS))) begin
        // The pointer stops one past the last register, so it never wraps back onto one.
        next_cmd_sel = 4'(cmd_sel + 4'h1);
      end
    end
  end

  // Register file next values; soft reset clears all registers.
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    if (byte_take && !byte_data[ROLE_BIT] && cmd_valid) begin
      if (soft_reset) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          next_regs[i] = REG_RESET;
        end
      end else if (cmd_sel < 4'(NUM_REGS)) begin
        next_regs[cmd_sel[2:0]] = {1'b0, byte_data[6:0]};
      end
    end
  end

  // Pointer state; the reset pin clears it and it holds while ce is low.
  // pointer reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_sel   <= 4'h0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_sel   <= next_cmd_sel;
      cmd_valid <= next_cmd_valid;
    end
  end

  // Register file state; the reset pin clears every entry to zero.
  // reset to zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // Reference clock decode of the next clock command image.
  // reference select decode
  always_comb begin
    next_ref_code      = {next_regs[0][FREQ_A_POS], next_regs[0][FREQ_B_POS], next_regs[0][FREQ_C_POS]};
    next_ref_known     = 1'b1;
    next_resistor_used = 1'b1;
    unique case (next_ref_code)
      SCC_REF_2FSC:    next_resistor_used = 1'b1;
      SCC_REF_4FSC:    next_resistor_used = 1'b0;
      SCC_REF_FSC:     next_resistor_used = 1'b1;
      SCC_REF_2FSC_NR: next_resistor_used = 1'b0;
      default:         next_ref_known     = 1'b0;
    endcase
  end

  // The stored frequency code is shown as written.
  assign ref_select = {regs[0][FREQ_A_POS], regs[0][FREQ_B_POS], regs[0][FREQ_C_POS]};

  // Test mode is passed on as stored; the host keeps it at zero.
  // test mode field
  assign test_mode_bit = regs[0][TEST_POS];

  // Phase offset in clock cycles; code 111 is the eighth position, 56 cycles late.
  // phase position map
  assign acq_phase         = regs[1][PHASE_LSB +: 3];
  assign next_phase_pos    = next_regs[1][PHASE_LSB +: 3];
  assign next_phase_offset = {3'b000, next_phase_pos} * 6'(PHASE_STEP_CYCLES);

  // Mode field and its class flags, decoded from the next image.
  // base mode decode
  assign slicer_mode      = regs[1][MODE_LSB +: 4];
  assign next_mode        = next_regs[1][MODE_LSB +: 4];
  assign next_mode_auto   = (next_mode == MODE_AUTO1) || (next_mode >= MODE_AUTO2);
  assign next_mode_header = (next_mode >= MODE_HDR1) && (next_mode < MODE_STAT1);
  assign next_mode_status = (next_mode >= MODE_STAT1) && (next_mode < MODE_PALPULS);

  // Error check kind: 0 biphase, 1 Hamming, 2 odd parity, 3 none.
  // check type select
  always_comb begin
    if (next_mode == MODE_VPS) begin
      next_check_kind = 2'h0;
    end else if (next_mode == MODE_PDC || next_mode == MODE_UDT || next_mode_status) begin
      next_check_kind = 2'h1;
    end else if (next_mode_header) begin
      next_check_kind = 2'h2;
    end else begin
      next_check_kind = 2'h3;
    end
  end

  // Control command 2 option bits; the range extension bit comes from register 4.
  // mask early start
  assign mask_early_start      = regs[2][MASK_EARLY_POS];
  assign mask_length_sel       = regs[2][MASK_LEN_POS];
  assign run_in_count_sel      = regs[2][RUN_IN_POS];
  assign framing_tolerance_sel = regs[2][FRAMING_POS];
  assign check_bypass          = regs[2][BYPASS_POS];
  assign errored_byte_policy   = regs[2][POLICY_POS];
  assign unused_byte_check_off = regs[2][UNUSED_OFF_POS];
  assign acquire_range_ext     = regs[4][RANGE_EXT_POS];

  // Count fields decode into line counts.
  // presence counts
  scc_count_decode u_count (
    .acq_code    (next_regs[3][ACQ_CNT_LSB +: 3]),
    .loss_code   (next_regs[3][LOSS_CNT_LSB +: 4]),
    .range_ext   (next_regs[4][RANGE_EXT_POS]),
    .acq_lines   (next_acq_lines),
    .acq_valid   (next_acq_valid),
    .loss_lines  (next_loss_lines),
    .loss_enable (next_loss_enable),
    .loss_valid  (next_loss_valid)
  );

  // Reference, phase and mode decodes are registered from the next image, so they
  // change on the same edge as the fields they come from.
  // Reset values are the decodes of an all-zero register file.
  // decode reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_select_known    <= 1'b1;
      phase_resistor_used <= 1'b1;
      acq_phase_offset    <= 6'h00;
      mode_auto           <= 1'b0;
      mode_header         <= 1'b0;
      mode_status         <= 1'b0;
      check_kind          <= 2'h0;
    end else begin
      ref_select_known    <= next_ref_known;
      phase_resistor_used <= next_resistor_used;
      acq_phase_offset    <= next_phase_offset;
      mode_auto           <= next_mode_auto;
      mode_header         <= next_mode_header;
      mode_status         <= next_mode_status;
      check_kind          <= next_check_kind;
    end
  end

  // Count decodes are registered the same way; reset shows zero counts, loss detection off.
  // count reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acq_lines          <= CNT_0;
      acq_code_valid     <= 1'b1;
      loss_lines         <= CNT_0;
      loss_detect_enable <= 1'b0;
      loss_code_valid    <= 1'b1;
    end else begin
      acq_lines          <= next_acq_lines;
      acq_code_valid     <= next_acq_valid;
      loss_lines         <= next_loss_lines;
      loss_detect_enable <= next_loss_enable;
      loss_code_valid    <= next_loss_valid;
    end
  end
endmodule
`default_nettype wire

// ==== dv/scc_regs_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
// Ties the decoded outputs to their stored fields and to the byte stream.
module scc_regs_sva
  import scc_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [2:0] ref_select,
  input wire logic       ref_select_known,
  input wire logic       phase_resistor_used,
  input wire logic [2:0] acq_phase,
  input wire logic [5:0] acq_phase_offset,
  input wire logic [3:0] slicer_mode,
  input wire logic       mode_auto,
  input wire logic       mode_header,
  input wire logic       check_bypass,
  input wire logic [8:0] acq_lines,
  input wire logic       acq_code_valid,
  input wire logic [8:0] loss_lines,
  input wire logic       loss_detect_enable,
  input wire logic       acquire_range_ext
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Steps of a soft reset: clock command byte, then data with bit 0 set.
  sequence s_clk_cmd; ce && byte_valid && byte_data == 8'hf0; endsequence
  sequence s_soft_data; ce && byte_valid && !byte_data[7] && byte_data[0]; endsequence
  property p_soft;
    s_clk_cmd ##1 s_soft_data |=> slicer_mode == 4'h0 && acq_phase == 3'h0 && ref_select == 3'h0
      && !check_bypass && !acquire_range_ext && loss_lines == 9'h000;
  endproperty
  property p_hold;
    !(ce && byte_valid) |=> $stable(slicer_mode) && $stable(ref_select) && $stable(acq_lines);
  endproperty
  property p_cmd_no_store;
    ce && byte_valid && byte_data[7] |=> $stable(slicer_mode) && $stable(loss_lines);
  endproperty
  property p_offset; acq_phase_offset == {acq_phase, 3'b000}; endproperty
  property p_auto; mode_auto == (slicer_mode inside {4'h2, 4'hd, 4'he, 4'hf}); endproperty
  property p_header; mode_header == (slicer_mode[3:2] == 2'b01); endproperty
  property p_ref; ref_select_known == (ref_select inside {3'b000, 3'b100, 3'b011, 3'b001}); endproperty
  property p_res; ref_select_known |-> phase_resistor_used == !(ref_select inside {3'b100, 3'b001}); endproperty
  property p_loss; loss_detect_enable |-> loss_lines inside {9'h020, 9'h040, 9'h080, 9'h100}; endproperty
  property p_ext; acq_code_valid && acquire_range_ext |-> acq_lines inside {9'h020, 9'h040, 9'h080, 9'h100};
  endproperty
  property p_rst; $fell(rst) |-> slicer_mode == 4'h0 && ref_select == 3'h0 && loss_lines == 9'h000; endproperty
  a_soft: assert property (p_soft) else $error("soft reset left a register set");
  a_hold: assert property (p_hold) else $error("register changed without a byte");
  a_cmd_no_store: assert property (p_cmd_no_store) else $error("command byte stored");
  a_offset: assert property (p_offset) else $error("phase offset wrong");
  a_auto: assert property (p_auto) else $error("auto mode decode wrong");
  a_header: assert property (p_header) else $error("header mode decode wrong");
  a_ref: assert property (p_ref) else $error("reference code flag wrong");
  a_res: assert property (p_res) else $error("phase resistor flag wrong");
  a_loss: assert property (p_loss) else $error("loss count wrong");
  a_ext: assert property (p_ext) else $error("extended count wrong");
  a_rst: assert property (p_rst) else $error("registers not clear after reset");
endmodule
bind scc_command_regs scc_regs_sva i_chk (.*);
`default_nettype wire

// ==== dv/scc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Byte source standing in for the serial front end driven by the host.
module scc_host_model
  import scc_pkg::*;
(
  input  wire logic  clk_sys,
  output logic       byte_valid,
  output logic [7:0] byte_data
);
  // Idle lines at time zero.
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  // whole bytes
  // One byte per cycle, back to back; the caller codes bit 7 and the command nibble.
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys);
    byte_valid <= 1'b1;
    byte_data <= b;
  endtask
  // Released data lines show the inverse of the last byte.
  task automatic idle();
    @(posedge clk_sys);
    byte_valid <= 1'b0;
    byte_data <= ~byte_data;
  endtask
endmodule
`default_nettype wire

// ==== dv/slicer_control_command_regs_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module slicer_control_command_regs_bench
  import scc_pkg::*;
;
  logic       clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, byte_valid;
  logic [7:0] byte_data, b;
  logic [2:0] ref_select, acq_phase;
  logic [5:0] acq_phase_offset;
  logic [3:0] slicer_mode;
  logic [1:0] check_kind;
  logic [8:0] acq_lines, loss_lines;
  logic       ref_select_known, phase_resistor_used, test_mode_bit, mode_auto, mode_header, mode_status;
  logic       mask_early_start, mask_length_sel, run_in_count_sel, framing_tolerance_sel, check_bypass;
  logic       errored_byte_policy, unused_byte_check_off, acq_code_valid, loss_detect_enable, loss_code_valid;
  logic       acquire_range_ext;
  logic [7:0] er [5] = '{default: 8'h00};
  logic [2:0] fc [4] = '{3'b000, 3'b100, 3'b011, 3'b001};
  logic [2:0] at [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [3:0] lt [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  logic [31:0] lfsr = 32'h00010820;
  int         ptr = 0, failures = 0, compares = 0;
  bit         ok = 1'b0;
  scc_command_regs i_dut (.*);
  scc_host_model i_host (.*);
  // Free-running system clock.
  always #50 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [8:0] exp_acq(input logic [2:0] c, input logic e);
    case (c)
      3'h0: return e ? 9'h020 : 9'h000;
      3'h1: return e ? 9'h040 : 9'h004;
      3'h2: return e ? 9'h080 : 9'h008;
      3'h4: return e ? 9'h100 : 9'h010;
      default: return 9'h000;
    endcase
  endfunction
  function automatic logic [8:0] exp_loss(input logic [3:0] c);
    return (c inside {4'h1, 4'h2, 4'h4, 4'h8}) ? {c, 5'h00} : 9'h000;
  endfunction
  function automatic logic [1:0] exp_kind(input logic [3:0] m);
    if (m == MODE_VPS) return 2'h0;
    if (m[3:2] == 2'b01) return 2'h2;
    return (m == MODE_PDC || m == MODE_UDT || m[3:2] == 2'b10) ? 2'h1 : 2'h3;
  endfunction
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Sends one byte and updates the expected register image.
  task automatic wr(input logic [7:0] v);
    i_host.send(v);
    if (!ce) return;
    if (v[7]) begin
      ok = v[7:4] == 4'hf;
      ptr = v[3:0];
    end else if (ok && ptr < NUM_REGS) begin
      if (ptr == 0 && v[0]) begin
        foreach (er[i]) er[i] = 8'h00;
      end else begin
        er[ptr] = v;
      end
      ptr++;
    end
  endtask
  task automatic chk();
    i_host.idle();
    @(posedge clk_sys);
    #1;
    cmp(ref_select, er[0][6:4]);
    cmp(test_mode_bit, er[0][2]);
    cmp(acq_phase_offset, {er[1][6:4], 3'h0});
    cmp(slicer_mode, er[1][3:0]);
    cmp({mask_early_start, mask_length_sel, run_in_count_sel, framing_tolerance_sel, check_bypass,
         errored_byte_policy, unused_byte_check_off}, er[2][6:0]);
    cmp(acq_lines, exp_acq(er[3][6:4], er[4][5]));
    cmp(loss_lines, exp_loss(er[3][3:0]));
    cmp(check_kind, exp_kind(er[1][3:0]));
    cmp(mode_status, er[1][3:2] == 2'b10);
    cmp(acquire_range_ext, er[4][5]);
    cmp(acq_code_valid, er[3][6:4] inside {3'h0, 3'h1, 3'h2, 3'h4});
    cmp(loss_code_valid, er[3][3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8});
  endtask
  task automatic give_verdict();
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence: directed corners, random traffic, then soft reset and pin reset.
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    chk();
    wr(8'h35);
    chk();
    for (int m = 0; m < 16; m++) begin
      wr(8'hf1);
      wr({1'b0, m[2:0] ^ 3'h5, m[3:0]});
      chk();
    end
    foreach (fc[i]) begin
      wr(8'hf0);
      wr({1'b0, fc[i], 4'h0});
      chk();
      cmp(ref_select_known, 1'b1);
      cmp(phase_resistor_used, !(fc[i] inside {3'b100, 3'b001}));
    end
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(8'hf2);
      wr({1'b0, lfsr[6:0]});
      wr({1'b0, at[i % 4], lt[i % 5]});
      wr({2'b00, i >= 5, 5'h00});
      wr(8'h7f);
      chk();
      cmp(acq_code_valid, 1'b1);
      cmp(loss_detect_enable, lt[i % 5] != 4'h0);
    end
    wr(8'hf5);
    wr(8'h11);
    wr(8'he1);
    wr(8'h22);
    chk();
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(8'hf1);
    wr(8'h7a);
    chk();
    @(posedge clk_sys);
    ce <= 1'b1;
    repeat (60) begin
      lfsr = lfsr_next(lfsr);
      b = lfsr[7:0];
      if (b[7] && lfsr[9]) b[7:4] = 4'hf;
      if (!b[7] && ptr == 0) b = b & 8'hfa;
      wr(b);
      if (lfsr[12:11] == 2'b00) chk();
    end
    wr(8'hf1);
    wr(8'h35);
    wr(8'hf0);
    wr(8'h01);
    chk();
    wr(8'hf3);
    wr(8'h24);
    i_host.idle();
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    foreach (er[i]) er[i] = 8'h00;
    ok = 1'b0;
    chk();
    give_verdict();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
